// >>> meas_cond_consts.svh
// Register indices, reset values, field positions and timing for conditioning
`ifndef MEAS_COND_CONSTS_SVH
`define MEAS_COND_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_AMB_HYST      6'h16
`define IDX_PROX_HYST     6'h17
`define IDX_PROX_MASK     6'h18
`define IDX_AMB_MASK      6'h19
`define IDX_OFFSET        6'h1a
`define IDX_LED_RECOVERY_RESERVED       6'h1c
`define IDX_IR_REC        6'h1d
`define IDX_IR_GAIN       6'h1e
`define IDX_PROX_TH1      6'h30
`define IDX_PROX_TH2      6'h31
`define IDX_PROX_TH3      6'h32
`define IDX_AMB_TH        6'h33
`define IDX_IRQ_STATUS    6'h34
`define IDX_IRQ_MASK      6'h35
`define IDX_LEVEL_STATUS  6'h36

// Reset values
`define RST_HYST          8'h48
`define RST_DEB_MASK      8'h03
`define RST_OFFSET        8'h80
`define RST_LED_RECOVERY_RESERVED       8'h00
`define RST_IR_REC        8'h70
`define RST_IR_GAIN       8'h00
`define RST_THRESHOLD     16'h0100
`define RST_IRQ           5'h00

// Field positions
`define REC_SEL_MSB       6
`define REC_SEL_LSB       4
`define GAIN_MSB          2
`define IRQ_REC_BIT       4

// Result codes
`define OVERRANGE_CODE    16'hffff
`define RESULT_CEILING    16'hfffe

// Sample kinds
`define KIND_AMB_VIS      3'h3
`define KIND_AMB_IR       3'h4

// Timing
`define ADC_CLK_NS        50
`define PCLK_NS           10

`endif

// >>> meas_cond_pkg.sv
// Types shared by the measurement conditioning block
package meas_cond_pkg;

  // One raw conversion from the ADC sequencer, relative and signed
  typedef struct packed {
    logic               valid;
    logic [2:0]         kind;
    logic               overrange;
    logic signed [15:0] value;
  } sample_type;

  // One conditioned result as reported to the result registers
  typedef struct packed {
    logic        valid;
    logic [2:0]  kind;
    logic [15:0] value;
  } result_type;

  typedef enum logic [0:0] {
    rec_idle,
    rec_wait
  } rec_state_type;

endpackage : meas_cond_pkg

// >>> meas_cond.sv
// Measurement conditioning: debounce, result offset, infrared recovery wait
//
// Behaviour
// - Proximity status flips after mask-popcount consecutive hits.
// - Ambient status flips after mask-popcount consecutive hits.
// - Offset code expands to sixteen bits and is added to every non-overrange result.
// - Result 0xffff means overrange only; normal results never reach it.
// - Infrared ambient conversion waits 1 to 511 ADC clocks by select.
// - Each recovery clock is 50 ns, scaled by two to the gain exponent.
// - Proximity debounce checks all three thresholds with shared hysteresis.
//
// The implementer's own choice: the APB slave port.
`include "meas_cond_consts.svh"

module meas_cond #(
  parameter int ADC_CLK_NS = `ADC_CLK_NS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire meas_cond_pkg::sample_type sample,
  input  wire logic                      ir_start,
  output meas_cond_pkg::result_type      result,
  output logic      [2:0]                prox_status,
  output logic                           ambient_status,
  output logic                           recovery_busy,
  output logic                           ir_convert_go,
  output logic                           irq
);

  localparam int ADC_CYC_RAW = (ADC_CLK_NS + `PCLK_NS - 1) / `PCLK_NS;
  localparam int ADC_CYC     = (ADC_CYC_RAW < 1) ? 1 : ADC_CYC_RAW;

  // Compressed code: top nibble exponent, low nibble mantissa with hidden one
  function automatic logic [15:0] expand(input logic [7:0] code);
    logic [23:0] t;
    t = 24'({20'h00001, code[3:0]} << code[7:4]) >> 4;
    expand = t[15:0];
  endfunction : expand

  // Number of ones in a debounce mask, never less than one sample
  function automatic logic [3:0] run_need(input logic [7:0] m);
    logic [3:0] n;
    n = 4'h0;
    for (int b = 0; b < 8; b++) begin
      n = n + {3'h0, m[b]};
    end
    run_need = (n == 4'h0) ? 4'h1 : n;
  endfunction : run_need

  // Recovery length in ADC clocks: 1, then two to the (select+2) less one
  function automatic logic [9:0] rec_clocks(input logic [2:0] s);
    rec_clocks = (s == 3'h0) ? 10'h001 :
                 10'((11'h001 << ({1'b0, s} + 4'h2)) - 11'h001);
  endfunction : rec_clocks

  // Register state
  logic [7:0]  amb_hyst_q, prox_hyst_q, prox_mask_q, amb_mask_q;
  logic [7:0]  offset_q, led_recovery_reserved_q, ir_rec_q, ir_gain_q;
  logic [15:0] th_q [4];
  logic [4:0]  irq_status_q, irq_mask_q, irq_event;
  logic        pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q, rdata_d;
  logic        mapped_d;
  logic [5:0]  idx;
  logic        access, wr_en;

  assign idx    = paddr[7:2];
  assign access = psel && penable && !pready_q;
  // Writes land on the edge that completes the transfer
  assign wr_en  = psel && penable && pready_q && pwrite;

  // Bus handshake: one wait state, then a one-cycle ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !mapped_d;
      prdata_q  <= (access && !pwrite && mapped_d) ? rdata_d : 32'h0;
    end
  end

  // Conditioning settings written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amb_hyst_q  <= `RST_HYST;
      prox_hyst_q <= `RST_HYST;
      prox_mask_q <= `RST_DEB_MASK;
      amb_mask_q  <= `RST_DEB_MASK;
      offset_q    <= `RST_OFFSET;
      led_recovery_reserved_q   <= `RST_LED_RECOVERY_RESERVED;
      ir_rec_q    <= `RST_IR_REC;
      ir_gain_q   <= `RST_IR_GAIN;
    end else if (wr_en) begin
      case (idx)
        `IDX_AMB_HYST:  amb_hyst_q  <= pwdata[7:0];
        `IDX_PROX_HYST: prox_hyst_q <= pwdata[7:0];
        `IDX_PROX_MASK: prox_mask_q <= pwdata[7:0];
        `IDX_AMB_MASK:  amb_mask_q  <= pwdata[7:0];
        `IDX_OFFSET:    offset_q    <= pwdata[7:0];
        `IDX_LED_RECOVERY_RESERVED:   led_recovery_reserved_q   <= pwdata[7:0];
        `IDX_IR_REC:    ir_rec_q    <= pwdata[7:0];
        `IDX_IR_GAIN:   ir_gain_q   <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Thresholds: three proximity, one ambient
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        th_q[i] <= `RST_THRESHOLD;
      end
    end else if (wr_en) begin
      case (idx)
        `IDX_PROX_TH1: th_q[0] <= pwdata[15:0];
        `IDX_PROX_TH2: th_q[1] <= pwdata[15:0];
        `IDX_PROX_TH3: th_q[2] <= pwdata[15:0];
        `IDX_AMB_TH:   th_q[3] <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky event bits, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= `RST_IRQ;
      irq_mask_q   <= `RST_IRQ;
      irq_q        <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q &
                       ~((wr_en && idx == `IDX_IRQ_STATUS) ?
                         pwdata[4:0] : 5'h00)) | irq_event;
      if (wr_en && idx == `IDX_IRQ_MASK) begin
        irq_mask_q <= pwdata[4:0];
      end
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // Read decode; unmapped indices answer with an error
  always_comb begin
    rdata_d  = 32'h0;
    mapped_d = 1'b1;
    case (idx)
      `IDX_AMB_HYST:     rdata_d[7:0]  = amb_hyst_q;
      `IDX_PROX_HYST:    rdata_d[7:0]  = prox_hyst_q;
      `IDX_PROX_MASK:    rdata_d[7:0]  = prox_mask_q;
      `IDX_AMB_MASK:     rdata_d[7:0]  = amb_mask_q;
      `IDX_OFFSET:       rdata_d[7:0]  = offset_q;
      `IDX_LED_RECOVERY_RESERVED:      rdata_d[7:0]  = led_recovery_reserved_q;
      `IDX_IR_REC:       rdata_d[7:0]  = ir_rec_q;
      `IDX_IR_GAIN:      rdata_d[7:0]  = ir_gain_q;
      `IDX_PROX_TH1:     rdata_d[15:0] = th_q[0];
      `IDX_PROX_TH2:     rdata_d[15:0] = th_q[1];
      `IDX_PROX_TH3:     rdata_d[15:0] = th_q[2];
      `IDX_AMB_TH:       rdata_d[15:0] = th_q[3];
      `IDX_IRQ_STATUS:   rdata_d[4:0]  = irq_status_q;
      `IDX_IRQ_MASK:     rdata_d[4:0]  = irq_mask_q;
      `IDX_LEVEL_STATUS: rdata_d[5:0]  = {recovery_busy, ambient_status,
                                          prox_status};
      default:           mapped_d      = 1'b0;
    endcase
  end

  // Offset correction with clamping so that only overrange gives all ones
  logic [15:0] offset_val;
  logic [17:0] sum;
  logic [15:0] res_d;
  meas_cond_pkg::result_type result_q;

  assign offset_val = expand(offset_q);
  assign sum = 18'({{2{sample.value[15]}}, sample.value}) +
               {2'b00, offset_val};

  always_comb begin
    if (sample.overrange) begin
      res_d = `OVERRANGE_CODE;
    end else if (sum[17]) begin
      res_d = 16'h0000;
    end else if (sum[16:0] >= {1'b0, `OVERRANGE_CODE}) begin
      res_d = `RESULT_CEILING;
    end else begin
      res_d = sum[15:0];
    end
  end

  // Conditioned result register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else begin
      result_q.valid <= sample.valid;
      result_q.kind  <= sample.kind;
      if (sample.valid) begin
        result_q.value <= res_d;
      end
    end
  end

  // Debounce: channels 0..2 proximity, channel 3 visible ambient
  logic [3:0] level_q;
  logic [3:0] run_q [4];
  logic [3:0] flip;

  for (genvar c = 0; c < 4; c++) begin : g_deb
    logic        hit, qual;
    logic [16:0] hyst, upper, lower_sum;
    logic [3:0]  need;

    assign hit  = sample.valid && !sample.overrange &&
                  (sample.kind == ((c < 3) ? 3'(c) : `KIND_AMB_VIS));
    assign hyst = {1'b0, expand((c < 3) ? prox_hyst_q : amb_hyst_q)};
    assign need = run_need((c < 3) ? prox_mask_q : amb_mask_q);
    assign upper     = {1'b0, th_q[c]} + hyst;
    assign lower_sum = {1'b0, res_d} + hyst;
    assign qual = level_q[c] ? (lower_sum < {1'b0, th_q[c]}) :
                               ({1'b0, res_d} > upper);
    assign flip[c] = hit && qual && (run_q[c] + 4'h1 >= need);

    // Run of consecutive qualifying samples; a non-qualifying, non-overrange sample of this kind restarts it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        run_q[c]   <= 4'h0;
        level_q[c] <= 1'b0;
      end else if (hit) begin
        if (flip[c]) begin
          run_q[c]   <= 4'h0;
          level_q[c] <= ~level_q[c];
        end else if (qual) begin
          run_q[c] <= run_q[c] + 4'h1;
        end else begin
          run_q[c] <= 4'h0;
        end
      end
    end
  end

  // Recovery wait ahead of each infrared ambient conversion
  meas_cond_pkg::rec_state_type rec_state_q;
  logic [23:0] rec_timer_q, rec_total;
  logic [16:0] rec_adc_clocks;
  logic        go_q, rec_done, busy_q;

  assign rec_adc_clocks = 17'({7'h0, rec_clocks(
                            ir_rec_q[`REC_SEL_MSB:`REC_SEL_LSB])}
                            << ir_gain_q[`GAIN_MSB:0]);
  assign rec_total = 24'({7'h0, rec_adc_clocks} * ADC_CYC);
  assign rec_done  = (rec_state_q == meas_cond_pkg::rec_wait) &&
                     (rec_timer_q == 24'h1);

  // Counts the wait down, then fires one conversion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_state_q <= meas_cond_pkg::rec_idle;
      rec_timer_q <= 24'h0;
      go_q        <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      go_q <= rec_done;
      case (rec_state_q)
        meas_cond_pkg::rec_idle: begin
          if (ir_start) begin
            rec_state_q <= meas_cond_pkg::rec_wait;
            rec_timer_q <= rec_total;
            busy_q      <= 1'b1;
          end
        end
        meas_cond_pkg::rec_wait: begin
          rec_timer_q <= rec_timer_q - 24'h1;
          if (rec_done) begin
            rec_state_q <= meas_cond_pkg::rec_idle;
            busy_q      <= 1'b0;
          end
        end
        default: begin
          rec_state_q <= meas_cond_pkg::rec_idle;
          busy_q      <= 1'b0;
        end
      endcase
    end
  end

  assign irq_event = {rec_done, flip};

  // Outputs
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign result         = result_q;
  assign prox_status    = level_q[2:0];
  assign ambient_status = level_q[3];
  assign recovery_busy  = busy_q;
  assign ir_convert_go  = go_q;
  assign irq            = irq_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  no_false_overrange_a: assert property (
    sample.valid && !sample.overrange |=> result.value != `OVERRANGE_CODE)
    else $error("normal result reported as overrange");
  overrange_passes_a: assert property (
    sample.valid && sample.overrange |=> result.value == `OVERRANGE_CODE)
    else $error("overrange not reported");
  offset_default_a: assert property (
    sample.valid && !sample.overrange && sample.value == 16'sh0000 &&
    offset_q == 8'h80 |=> result.value == 16'h0100)
    else $error("offset code 0x80 did not add 256");
  prox_run_a: assert property (
    $changed(prox_status[0]) |-> $past(run_q[0]) + 4'h1 >=
                                 $past(run_need(prox_mask_q)))
    else $error("proximity status flipped before its run");
  prox_two_a: assert property (
    $changed(prox_status[1]) && $past(prox_mask_q) == 8'h07 |->
      $past(run_q[1]) == 4'h2)
    else $error("threshold two flipped without three samples");
  amb_run_a: assert property (
    $changed(ambient_status) && $past(amb_mask_q) == 8'hff |->
      $past(run_q[3]) == 4'h7)
    else $error("ambient status flipped before eight samples");
  rec_short_a: assert property (
    !recovery_busy && ir_start && ir_rec_q[6:4] == 3'h0 &&
    ir_gain_q[2:0] == 3'h0 |=> recovery_busy [*5] ##1 ir_convert_go)
    else $error("shortest recovery not one ADC clock");
  rec_gain_a: assert property (
    !recovery_busy && ir_start && ir_rec_q[6:4] == 3'h1 &&
    ir_gain_q[2:0] == 3'h1 |-> ##71 ir_convert_go)
    else $error("recovery not scaled by gain");
  irq_level_a: assert property (
    |(irq_status_q & irq_mask_q) |=> irq)
    else $error("interrupt missing for unmasked status");

  prox_flip_c: cover property ($rose(prox_status[0]));
  amb_flip_c:  cover property ($rose(ambient_status));
  rec_go_c:    cover property (ir_convert_go);
  clamp_c:     cover property (sample.valid && sum[16:0] >= 17'h0ffff);

endmodule : meas_cond

// >>> host_model.sv
// Host model: APB master that configures the conditioning block
`include "meas_cond_consts.svh"

module host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; holds the request until pready is seen high
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;  // Released lines carry no stale value
    pwdata  <= ~pwdata;
  endtask : xfer

  // Gain exponent, then select as its inverse; reserved bits written 0
  // The LED word is never written, so it keeps its reset value
  task automatic set_recovery(input logic [2:0] gain);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, `IDX_IR_GAIN, {29'h0, gain}, rd, err);
    xfer(1'b1, `IDX_IR_REC, {24'h0, 1'b0, ~gain, 4'h0}, rd,
         err);
  endtask : set_recovery
endmodule : host_model

// >>> measurement_debounce_offset_recovery_tb_top.sv
// Testbench for the measurement conditioning block
`include "meas_cond_consts.svh"

module measurement_debounce_offset_recovery_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      pclk;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [7:0]                paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  meas_cond_pkg::sample_type sample;
  logic                      ir_start;
  meas_cond_pkg::result_type result;
  logic [2:0]                prox_status;
  logic                      ambient_status;
  logic                      recovery_busy;
  logic                      ir_convert_go;
  logic                      irq;
  int                        num_errors;
  int                        total_checks;
  int                        n;
  logic [31:0]               rd;
  logic                      err;
  logic [5:0]  ridx [5] = '{6'h18, 6'h19, 6'h1a, 6'h1c, 6'h1d};
  logic [7:0]  rrst [5] = '{8'h03, 8'h03, 8'h80, 8'h00, 8'h70};
  logic [7:0]  ocode [3] = '{8'h60, 8'h70, 8'h80};
  logic [15:0] oval [3] = '{16'h0040, 16'h0080, 16'h0100};
  int          rclk [8] = '{1, 7, 15, 31, 63, 127, 255, 511};

  meas_cond u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
    .ir_start(ir_start), .result(result), .prox_status(prox_status),
    .ambient_status(ambient_status), .recovery_busy(recovery_busy),
    .ir_convert_go(ir_convert_go), .irq(irq));

  host_model u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Clock
  always #(`PCLK_NS / 2) pclk = ~pclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    u_host.xfer(1'b1, idx, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    u_host.xfer(1'b0, idx, 32'h0000_0000, rd, err);
    check(rd, exp);
  endtask : rd_chk

  // Samples go out cnt per call, one every two clocks; outputs are read mid-cycle after taken
  task automatic run(input logic [2:0] kind, input int cnt,
                     input logic [15:0] val, input logic ovr);
    repeat (cnt) begin
      @(posedge pclk);
      sample <= '{1'b1, kind, ovr, val};
      @(posedge pclk);
      sample.valid <= 1'b0;
      @(negedge pclk);
    end
  endtask : run

  // Starts one recovery, with a repeat request while busy, and counts it
  task automatic rec_chk(input int adc);
    @(posedge pclk);
    ir_start <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      ir_start <= (n == 2);
      if (recovery_busy === 1'b1) n++;
    end while (ir_convert_go !== 1'b1);
    check(32'(n), 32'(adc * (`ADC_CLK_NS / `PCLK_NS)));
    @(posedge pclk);
    check(ir_convert_go, 1'b0);
  endtask : rec_chk

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog against a hung handshake
  initial begin
    #(`PCLK_NS * 40000);
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    sample = '0;
    ir_start = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_chk(ridx[i], {24'h0, rrst[i]});
    end
    u_host.xfer(1'b0, 6'h3f, 32'h0000_0000, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    // Offset codes on an infrared sample of zero
    for (int i = 0; i < 3; i++) begin
      wr(`IDX_OFFSET, {24'h0, ocode[i]});
      run(`KIND_AMB_IR, 1, 16'h0000, 1'b0);
      check(result.valid, 1'b1);
      check(result.kind, `KIND_AMB_IR);
      check(result.value, oval[i]);
    end
    // Ceiling, overrange and negative results
    wr(`IDX_OFFSET, 32'h0000_00ff);
    run(`KIND_AMB_IR, 1, 16'h7fff, 1'b0);
    check(result.value, 16'hfffe);
    run(`KIND_AMB_IR, 1, 16'h0000, 1'b1);
    check(result.value, 16'hffff);
    wr(`IDX_OFFSET, 32'h0000_0060);
    run(`KIND_AMB_IR, 1, 16'hff9c, 1'b0);
    check(result.value, 16'h0000);
    wr(`IDX_OFFSET, 32'h0000_0080);
    // Runs of three on each proximity threshold; 24 sits on the boundary
    wr(`IDX_PROX_MASK, 32'h0000_0007);
    for (int k = 0; k < 3; k++) begin
      run(3'(k), 2, 16'd25, 1'b0);
      run(3'(k), 1, 16'd24, 1'b0);
      run(3'(k), 2, 16'd25, 1'b0);
      check(prox_status[k], 1'b0);
      run(3'(k), 1, 16'd25, 1'b0);
      check(prox_status[k], 1'b1);
    end
    // Ambient run of eight
    wr(`IDX_AMB_MASK, 32'h0000_00ff);
    run(`KIND_AMB_VIS, 7, 16'd25, 1'b0);
    check(ambient_status, 1'b0);
    run(`KIND_AMB_VIS, 1, 16'd25, 1'b0);
    check(ambient_status, 1'b1);
    // Every select code and gain, then two settings off the advice
    for (int g = 0; g < 8; g++) begin
      u_host.set_recovery(3'(g));
      rec_chk(rclk[7-g] << g);
    end
    wr(`IDX_IR_GAIN, 32'h0000_0000);
    wr(`IDX_IR_REC, 32'h0000_0000);
    rec_chk(rclk[0]);
    wr(`IDX_IR_GAIN, 32'h0000_0001);
    wr(`IDX_IR_REC, 32'h0000_0010);
    rec_chk(rclk[1] << 1);
    // Sticky events, mask and clear
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_001f);
    rd_chk(`IDX_LEVEL_STATUS, 32'h0000_000f);
    check(irq, 1'b0);
    wr(`IDX_IRQ_MASK, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    wr(`IDX_IRQ_STATUS, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_000f);
    end_sim();
  end
endmodule : measurement_debounce_offset_recovery_tb_top
